// ### cc3_map.vh
`ifndef CC3_MAP_VH
`define CC3_MAP_VH

// ************************************************************
// register indices (printed offsets)
// ************************************************************
`define CC3_IDX_STAGE1_COUNTS 9'h19e
`define CC3_IDX_PHASE         9'h19f
`define CC3_IDX_STAGE2_COUNTS 9'h1a0
`define CC3_IDX_CONTROL       9'h1a1
`define CC3_IDX_DUTY          9'h1a2
`define CC3_IDX_STATUS        9'h1a3

// ************************************************************
// byte addresses on the bus, four times the index
// ************************************************************
`define CC3_ADDR_W            12
`define CC3_ADDR_STAGE1_COUNTS 12'h678
`define CC3_ADDR_PHASE         12'h67c
`define CC3_ADDR_STAGE2_COUNTS 12'h680
`define CC3_ADDR_CONTROL       12'h684
`define CC3_ADDR_DUTY          12'h688
`define CC3_ADDR_STATUS        12'h68c

// ************************************************************
// reset values
// ************************************************************
`define CC3_RST_COUNTS        8'h00
`define CC3_RST_PHASE         8'h00
`define CC3_RST_CONTROL       8'h00
`define CC3_RST_DUTY          1'b0

// ************************************************************
// field positions
// ************************************************************
`define CC3_F_LOW_HI          7
`define CC3_F_LOW_LO          4
`define CC3_F_HIGH_HI         3
`define CC3_F_HIGH_LO         0
`define CC3_F_PH2_HI          7
`define CC3_F_PH2_LO          4
`define CC3_F_PH1_HI          3
`define CC3_F_PH1_LO          0
`define CC3_F_BYPASS2         5
`define CC3_F_BYPASS1         4
`define CC3_F_NOSYNC          3
`define CC3_F_FORCE           2
`define CC3_F_START2          1
`define CC3_F_START1          0
`define CC3_F_DCC_OFF         0

`endif

// ### cc3_channel_divider.v
`timescale 1ns/100ps
`default_nettype none
`include "cc3_map.vh"

module cc3_channel_divider (
  input  wire                     pclk,
  input  wire                     presetn,
  input  wire                     clk_en,
  input  wire                     psel,
  input  wire                     penable,
  input  wire                     pwrite,
  input  wire [`CC3_ADDR_W-1:0]   paddr,
  input  wire [31:0]              pwdata,
  output wire                     pready,
  output wire                     pslverr,
  output wire [31:0]              prdata,
  input  wire                     sync_n,
  output wire                     chan_clk_out
);

  // ************************************************************
  // shared declarations
  // ************************************************************
  wire        restart;
  wire        nosync;
  reg  [1:0]  lvl_q;

  // ************************************************************
  // register file
  // ************************************************************
  reg  [7:0]  stage1_counts_q;
  reg  [7:0]  phase_q;
  reg  [7:0]  stage2_counts_q;
  reg  [7:0]  control_q;
  reg         duty_correction_disable_q;
  reg  [31:0] prdata_q;
  reg  [7:0]  rd_d;
  reg         hit_d;

  wire        wr_en;
  wire        setup;

  // setup cycle of a transfer
  assign setup   = psel & ~penable;

  // writes land in the access cycle
  assign wr_en   = psel & penable & pwrite & clk_en;

  // zero wait states
  assign pready  = 1'b1;

  // unmapped offsets answer with an error
  assign pslverr = psel & penable & ~hit_d;

  assign prdata  = prdata_q;

  always @* begin
    rd_d  = 8'h00;
    hit_d = 1'b1;
    case (paddr)
      `CC3_ADDR_STAGE1_COUNTS: begin
        rd_d = stage1_counts_q;
      end
      `CC3_ADDR_PHASE: begin
        rd_d = phase_q;
      end
      `CC3_ADDR_STAGE2_COUNTS: begin
        rd_d = stage2_counts_q;
      end
      `CC3_ADDR_CONTROL: begin
        rd_d = control_q;
      end
      `CC3_ADDR_DUTY: begin
        rd_d = {7'h00, duty_correction_disable_q};
      end
      // status: restart, output, stage levels
      `CC3_ADDR_STATUS: begin
        rd_d = {4'h0, restart, chan_clk_out, lvl_q};
      end
      default: begin
        hit_d = 1'b0;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_counts_q           <= `CC3_RST_COUNTS;
      phase_q                   <= `CC3_RST_PHASE;
      stage2_counts_q           <= `CC3_RST_COUNTS;
      control_q                 <= `CC3_RST_CONTROL;
      duty_correction_disable_q <= `CC3_RST_DUTY;
      prdata_q                  <= 32'h00000000;
    end else if (clk_en) begin
      // read data is captured in the setup cycle
      if (setup && !pwrite) begin
        prdata_q <= {24'h000000, rd_d};
      end

      // only mapped offsets take a write
      if (wr_en) begin
        case (paddr)
          `CC3_ADDR_STAGE1_COUNTS: begin
            stage1_counts_q <= pwdata[7:0];
          end
          `CC3_ADDR_PHASE: begin
            phase_q <= pwdata[7:0];
          end
          `CC3_ADDR_STAGE2_COUNTS: begin
            stage2_counts_q <= pwdata[7:0];
          end
          `CC3_ADDR_CONTROL: begin
            control_q <= pwdata[7:0];
          end
          `CC3_ADDR_DUTY: begin
            duty_correction_disable_q <= pwdata[`CC3_F_DCC_OFF];
          end
          default: begin
            prdata_q <= prdata_q;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // chip-level sync synchroniser
  // ************************************************************
  // two flops, only the second is read
  reg  sync_meta_q;
  reg  sync_n_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_meta_q <= 1'b1;
      sync_n_q    <= 1'b1;
    end else if (clk_en) begin
      sync_meta_q <= sync_n;
      sync_n_q    <= sync_meta_q;
    end
  end

  // sync-ignore bit
  assign nosync  = control_q[`CC3_F_NOSYNC];

  // restart holds while the synced pin stays low
  assign restart = ~sync_n_q & ~nosync;

  // ************************************************************
  // stage limits and duty correction
  // ************************************************************
  wire [3:0] low1;
  wire [3:0] high1;
  wire [3:0] low2;
  wire [3:0] high2;
  wire [5:0] tot2;
  wire [5:0] half2;
  wire [5:0] dcc_h;
  wire [5:0] dcc_l;
  wire       dcc_on;

  // stage one low and high counts
  assign low1   = stage1_counts_q[`CC3_F_LOW_HI:`CC3_F_LOW_LO];
  assign high1  = stage1_counts_q[`CC3_F_HIGH_HI:`CC3_F_HIGH_LO];

  // stage two low and high counts
  assign low2   = stage2_counts_q[`CC3_F_LOW_HI:`CC3_F_LOW_LO];
  assign high2  = stage2_counts_q[`CC3_F_HIGH_HI:`CC3_F_HIGH_LO];

  // stage two period, low plus high plus two
  assign tot2   = {2'b00, low2} + {2'b00, high2} + 6'h02;

  // corrected high half rounds down
  assign half2  = {1'b0, tot2[5:1]};

  // corrected high limit
  assign dcc_h  = half2 - 6'h01;

  // corrected low limit takes the rest of the period
  assign dcc_l  = tot2 - half2 - 6'h01;

  assign dcc_on = ~duty_correction_disable_q;

  // ************************************************************
  // per-stage vectors, stage one in [4:0] or bit 0, stage two in [9:5] or bit 1
  // ************************************************************
  wire [9:0] lim_l;
  wire [9:0] lim_h;
  wire [9:0] phase_v;
  wire [1:0] byp;
  wire [1:0] start;
  wire [1:0] tick_in;
  wire [1:0] tick_out;
  reg  [9:0] cnt_q;

  // stage one limits
  assign lim_l[4:0]   = {1'b0, low1};
  assign lim_h[4:0]   = {1'b0, high1};

  // stage two limits, corrected or programmed
  assign lim_l[9:5]   = dcc_on ? dcc_l[4:0] : {1'b0, low2};
  assign lim_h[9:5]   = dcc_on ? dcc_h[4:0] : {1'b0, high2};

  // phase offsets preloaded on restart
  assign phase_v[4:0] = {1'b0, phase_q[`CC3_F_PH1_HI:`CC3_F_PH1_LO]};
  assign phase_v[9:5] = {1'b0, phase_q[`CC3_F_PH2_HI:`CC3_F_PH2_LO]};

  // bypass bits
  assign byp          = {control_q[`CC3_F_BYPASS2], control_q[`CC3_F_BYPASS1]};

  // start levels
  assign start        = {control_q[`CC3_F_START2], control_q[`CC3_F_START1]};

  // stage one runs on every input cycle
  assign tick_in[0]   = 1'b1;

  // stage two counts stage one rising edges
  assign tick_in[1]   = byp[0] ? 1'b1 : tick_out[0];

  // ************************************************************
  // cascaded stages
  // ************************************************************
  genvar g;

  generate
    for (g = 0; g < 2; g = g + 1) begin : stage
      wire [4:0] cnt;
      wire [4:0] lim;
      wire       term;
      wire       hold;

      // current count of this stage
      assign cnt = cnt_q[g*5+4:g*5];

      // limit of the segment now running
      assign lim = lvl_q[g] ? lim_h[g*5+4:g*5] : lim_l[g*5+4:g*5];

      // segment ends once the count reaches its limit
      assign term = (cnt >= lim);

      // restart or bypass hold the stage at its preload
      assign hold = restart | byp[g];

      // one pulse on each rising edge of the stage output
      assign tick_out[g] = clk_en & ~hold & tick_in[g] & term & ~lvl_q[g];

      // level flips and count clears at each limit
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          lvl_q[g]           <= 1'b0;
          cnt_q[g*5+4:g*5]   <= 5'h00;
        end else if (clk_en) begin
          // preload start level and phase offset
          if (hold) begin
            lvl_q[g]         <= start[g];
            cnt_q[g*5+4:g*5] <= phase_v[g*5+4:g*5];
          end else if (tick_in[g]) begin
            // count up to the limit, then flip
            if (term) begin
              lvl_q[g]         <= ~lvl_q[g];
              cnt_q[g*5+4:g*5] <= 5'h00;
            end else begin
              cnt_q[g*5+4:g*5] <= cnt + 5'h01;
            end
          end
        end
      end
    end
  endgenerate

  // ************************************************************
  // output select
  // ************************************************************
  wire stage1_out;
  wire stage2_out;
  wire forced;

  // a bypassed first stage passes the input clock
  assign stage1_out = byp[0] ? pclk : lvl_q[0];

  // a bypassed second stage passes the first stage output
  assign stage2_out = byp[1] ? stage1_out : lvl_q[1];

  // force high only takes effect with sync ignored
  assign forced = nosync & control_q[`CC3_F_FORCE];

  assign chan_clk_out = forced ? 1'b1 : stage2_out;

endmodule
`default_nettype wire

// ### cc3_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "cc3_map.vh"
module cc3_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        sync_n,
  input wire logic        chan_clk_out
);
  logic [7:0] ctl_q;
  logic [3:0] sy_q;
  wire        acc = psel && penable && clk_en;
  wire        mp  = paddr[1:0] == 2'h0 && paddr >= `CC3_ADDR_STAGE1_COUNTS
                    && paddr <= `CC3_ADDR_STATUS;
  // shadow of the control word and of the sync pin history
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= 8'h00;
      sy_q <= 4'hf;
    end else begin
      sy_q <= {sy_q[2:0], sync_n};
      if (acc && pwrite && paddr == `CC3_ADDR_CONTROL) ctl_q <= pwdata[7:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready) else $error("ready low");
  a_err_unmapped: assert property (acc && !mp |-> pslverr) else $error("no error");
  a_err_mapped: assert property (acc && mp |-> !pslverr) else $error("bad error");
  a_err_zero: assert property (acc && !pwrite && !mp |-> prdata == 32'h0) else $error("data");
  a_rdata_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper");
  a_read_ctl: assert property (acc && !pwrite && paddr == `CC3_ADDR_CONTROL
    |-> prdata[7:0] == ctl_q) else $error("control");
  a_force_high: assert property (ctl_q[3] && ctl_q[2] |-> chan_clk_out) else $error("force");
  a_sync_start: assert property (sy_q == 4'h0 && !ctl_q[3] && !(ctl_q[5] && ctl_q[4])
    && $stable(ctl_q) |-> chan_clk_out == (ctl_q[5] ? ctl_q[0] : ctl_q[1])) else $error("start");
endmodule
bind cc3_channel_divider cc3_chk u_chk (.*);
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "cc3_map.vh"
module tb_top;
  logic        pclk = 1'h0, presetn = 1'h0, sync_n = 1'h1;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, q;
  logic        e;
  wire         pready, pslverr, chan_clk_out;
  wire  [31:0] prdata;
  int          fail_count = 0, tests_run = 0, lo, hi, i;
  always #2.5 pclk = ~pclk;
  cc3_channel_divider dut (.pclk(pclk), .presetn(presetn), .clk_en(1'h1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .sync_n(sync_n), .chan_clk_out(chan_clk_out));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[FAIL] %s exp %h got %h", n, e, g);
      fail_count++;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  // program the channel, restart it and check the level held meanwhile
  task cfg(input logic [7:0] c, s1, s2, input logic d);
    apb(1'h1, `CC3_ADDR_CONTROL, {24'h0, c});
    apb(1'h1, `CC3_ADDR_STAGE1_COUNTS, {24'h0, s1});
    apb(1'h1, `CC3_ADDR_STAGE2_COUNTS, {24'h0, s2});
    apb(1'h1, `CC3_ADDR_DUTY, {31'h0, d});
    sync_n <= 1'h0;
    repeat (6) @(posedge pclk);
    @(negedge pclk);
    if (c[2] || !c[3]) chk("start", c[3] || (c[5] ? c[0] : c[1]), chan_clk_out);
    @(posedge pclk);
    sync_n <= ~c[3];
    @(posedge pclk);
  endtask
  // measure one whole high and low segment of the output
  task dv(input logic [7:0] c, s1, s2, input logic d, input int el, eh);
    cfg(c, s1, s2, d);
    @(negedge pclk);
    while (chan_clk_out === 1'h1) @(negedge pclk);
    while (chan_clk_out !== 1'h1) @(negedge pclk);
    for (hi = 0; chan_clk_out === 1'h1; hi++) @(negedge pclk);
    for (lo = 0; chan_clk_out !== 1'h1; lo++) @(negedge pclk);
    chk("low", el, lo);
    chk("high", eh, hi);
    @(posedge pclk);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #20000;
    fail_count++;
    end_sim;
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (i = 0; i < 5; i++) begin
      apb(1'h0, `CC3_ADDR_STAGE1_COUNTS + 12'(4 * i), 32'h0);
      chk("reset", 32'h0, q);
      chk("slverr", 32'h0, {31'h0, e});
    end
    apb(1'h1, `CC3_ADDR_PHASE, 32'h5a);
    apb(1'h0, `CC3_ADDR_PHASE, 32'h0);
    chk("phase", 32'h5a, q);
    apb(1'h0, 12'h690, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    dv(8'h12, 8'h00, 8'h31, 1'h1, 4, 2);
    dv(8'h10, 8'h00, 8'h31, 1'h0, 3, 3);
    dv(8'h00, 8'h11, 8'h00, 1'h1, 4, 4);
    dv(8'h21, 8'h21, 8'h00, 1'h1, 3, 2);
    dv(8'h18, 8'h00, 8'h00, 1'h1, 1, 1);
    cfg(8'h0c, 8'h00, 8'h00, 1'h1);
    end_sim;
  end
endmodule
`default_nettype wire
